//--- src/bam_pkg.sv
// ==========================================================
// shared constants for the address status / mode block
// ==========================================================
package bam_pkg;

  // register port: both registers share one offset
  localparam logic [8:0] REG_OFFSET = 9'h119;

  // address mode control fields (write side)
  localparam int SEND_ONLY_POS = 7;
  localparam int RECV_ONLY_POS = 6;
  localparam int DIR_HI_POS = 5;
  localparam int DIR_LO_POS = 4;
  localparam int MODE_HI_POS = 1;
  localparam int MODE_LO_POS = 0;

  // address status fields (read side)
  localparam int LPRI_SEEN_POS = 4;
  localparam int TPRI_SEEN_POS = 3;
  localparam int LISTEN_POS = 2;
  localparam int SEND_ROLE_POS = 1;
  localparam int MINOR_POS = 0;

  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic [7:0] RD_RESET = 8'h00;

  // address modes
  localparam logic [1:0] MODE_ONLY = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_EXT_SINGLE = 2'h2;
  localparam logic [1:0] MODE_EXT_DUAL = 2'h3;

  // command byte groups, taken from bits 6..5
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam logic [4:0] ADDR_ALL_ONES = 5'h1f;

  // primary address tracking for extended modes
  typedef enum logic [2:0] {
    PRI_IDLE = 3'h1,
    PRI_TALK = 3'h2,
    PRI_LISTEN = 3'h4
  } bam_pri_t;

endpackage : bam_pkg

//--- src/bam_cmd_decode.sv
`timescale 1ns/1ns
// ==========================================================
// command byte classifier
// ==========================================================
module bam_cmd_decode (
  input wire logic [6:0] i_cmd_byte,
  output logic o_listen,
  output logic o_talk,
  output logic o_secondary,
  output logic o_unaddress,
  output logic [4:0] o_addr
);

  logic [1:0] grp;

  // group and five-bit address; all-ones address means unlisten/untalk
  always_comb
  begin
    grp = i_cmd_byte[6:5];
    o_addr = i_cmd_byte[4:0];
    o_unaddress = (i_cmd_byte[4:0] == bam_pkg::ADDR_ALL_ONES);
    o_listen = (grp == bam_pkg::GRP_LISTEN);
    o_talk = (grp == bam_pkg::GRP_TALK);
    // the all-ones secondary is not a usable address
    o_secondary = (grp == bam_pkg::GRP_SECONDARY) && !o_unaddress;
  end

endmodule : bam_cmd_decode

//--- src/bam_addr_match.sv
`timescale 1ns/1ns
// ==========================================================
// address comparator with enable
// ==========================================================
module bam_addr_match (
  input wire logic i_enable,
  input wire logic [4:0] i_addr,
  input wire logic [4:0] i_own_addr,
  output logic o_match
);

  // a disabled function never matches, so it cannot be addressed
  always_comb
  begin
    o_match = i_enable && (i_addr == i_own_addr);
  end

endmodule : bam_addr_match

//--- src/bam_addr_status.sv
`timescale 1ns/1ns
module bam_addr_status (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic i_chip_reset,
  input wire logic i_pon_cmd,
  input wire logic i_cmd_valid,
  input wire logic [6:0] i_cmd_byte,
  input wire logic [4:0] i_first_addr,
  input wire logic [4:0] i_second_addr,
  input wire logic i_sec_valid,
  input wire logic i_sec_invalid,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [1:0] o_driver_dir_ctrl,
  output logic o_listen_active,
  output logic o_send_role,
  output logic o_sec_hold
);

  // ========================================================
  // state
  logic [1:0] mode_r, mode_nxt;
  logic [1:0] dir_r, dir_nxt;
  logic send_only_r, send_only_nxt;
  logic recv_only_r, recv_only_nxt;
  logic talk_r, talk_nxt;
  logic listen_r, listen_nxt;
  logic minor_r, minor_nxt;
  logic pri_minor_r, pri_minor_nxt;
  logic hold_r, hold_nxt;
  bam_pkg::bam_pri_t pri_r, pri_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic is_listen, is_talk, is_sec, is_unaddr;
  logic [4:0] cmd_addr;
  logic dual_mode, ext_mode;
  logic major_hit, minor_hit, own_hit, sec_hit;
  logic wr_hit, rd_hit, clear_cmd, cmd_take;
  logic [7:0] status;
  // ========================================================
  // command decode and address compare
  bam_cmd_decode u_decode (
    .i_cmd_byte(i_cmd_byte),
    .o_listen(is_listen),
    .o_talk(is_talk),
    .o_secondary(is_sec),
    .o_unaddress(is_unaddr),
    .o_addr(cmd_addr)
  );
  // major/primary address is live in every addressing mode except mode 0
  bam_addr_match u_major (
    .i_enable(mode_r != bam_pkg::MODE_ONLY),
    .i_addr(cmd_addr),
    .i_own_addr(i_first_addr),
    .o_match(major_hit)
  );
  // second register is a minor primary only in dual modes
  bam_addr_match u_minor (
    .i_enable(dual_mode),
    .i_addr(cmd_addr),
    .i_own_addr(i_second_addr),
    .o_match(minor_hit)
  );

  // mode classes and strobes
  always_comb
  begin
    dual_mode = mode_r[bam_pkg::MODE_LO_POS];
    ext_mode = mode_r[bam_pkg::MODE_HI_POS];
    own_hit = (major_hit || minor_hit) && !is_unaddr;
    sec_hit = is_sec && (cmd_addr == i_second_addr);
    wr_hit = i_wr_en && (i_reg_addr == bam_pkg::REG_OFFSET);
    rd_hit = i_rd_en && (i_reg_addr == bam_pkg::REG_OFFSET);
    clear_cmd = i_chip_reset || i_pon_cmd;
    // mode 0 ignores every bus address command; a held secondary blocks more
    cmd_take = i_cmd_valid && (mode_r != bam_pkg::MODE_ONLY) && !hold_r;
  end
  // ========================================================
  // addressing next state
  always_comb
  begin
    mode_nxt = mode_r;
    dir_nxt = dir_r;
    send_only_nxt = send_only_r;
    recv_only_nxt = recv_only_r;
    talk_nxt = talk_r;
    listen_nxt = listen_r;
    minor_nxt = minor_r;
    pri_minor_nxt = pri_minor_r;
    hold_nxt = hold_r;
    pri_nxt = pri_r;
    if (clear_cmd)
    begin
      // chip reset and power-on command drop all addressing
      talk_nxt = 1'b0;
      listen_nxt = 1'b0;
      minor_nxt = 1'b0;
      hold_nxt = 1'b0;
      pri_nxt = bam_pkg::PRI_IDLE;
    end
    else if (hold_r)
    begin
      // mode 3: acceptor waits for software verdict on the secondary
      if (i_sec_valid)
      begin
        // a held primary is talk or listen, never idle
        talk_nxt = (pri_r == bam_pkg::PRI_TALK);
        listen_nxt = listen_r || (pri_r == bam_pkg::PRI_LISTEN);
        minor_nxt = pri_minor_r;
        hold_nxt = 1'b0;
        pri_nxt = bam_pkg::PRI_IDLE;
      end
      else if (i_sec_invalid)
      begin
        hold_nxt = 1'b0;
        pri_nxt = bam_pkg::PRI_IDLE;
      end
    end
    else if (cmd_take)
    begin
      // the strobe covers bytes we send as controller and bytes received
      if (is_listen && is_unaddr)
      begin
        listen_nxt = 1'b0;
        pri_nxt = bam_pkg::PRI_IDLE;
      end
      else if (is_listen && own_hit && !ext_mode)
      begin
        listen_nxt = 1'b1;
        talk_nxt = 1'b0;
        minor_nxt = minor_hit && !major_hit;
      end
      else if (is_listen && own_hit)
      begin
        pri_nxt = bam_pkg::PRI_LISTEN;
        pri_minor_nxt = minor_hit && !major_hit;
      end
      else if (is_talk && own_hit && !ext_mode)
      begin
        talk_nxt = 1'b1;
        minor_nxt = minor_hit && !major_hit;
      end
      else if (is_talk && own_hit)
      begin
        pri_nxt = bam_pkg::PRI_TALK;
        pri_minor_nxt = minor_hit && !major_hit;
      end
      else if (is_talk)
      begin
        // untalk, or another talker addressed: give the bus up
        talk_nxt = 1'b0;
        pri_nxt = bam_pkg::PRI_IDLE;
      end
      else if (is_sec && (pri_r != bam_pkg::PRI_IDLE))
      begin
        if (dual_mode)
        begin
          // mode 3: software inspects the secondary, flag stays visible
          hold_nxt = 1'b1;
        end
        else
        begin
          // mode 2: hardware checks the secondary itself; a miss changes no role
          talk_nxt = sec_hit ? (pri_r == bam_pkg::PRI_TALK) : talk_r;
          listen_nxt = listen_r || (sec_hit && (pri_r == bam_pkg::PRI_LISTEN));
          pri_nxt = bam_pkg::PRI_IDLE;
        end
      end
    end
    // a register write follows bus commands in one cycle; overrides pri and hold; send-only adds to talk; receive-only sets listen, ties talk to send-only
    if (wr_hit)
    begin
      mode_nxt = i_wr_data[bam_pkg::MODE_HI_POS:bam_pkg::MODE_LO_POS];
      dir_nxt = i_wr_data[bam_pkg::DIR_HI_POS:bam_pkg::DIR_LO_POS];
      send_only_nxt = i_wr_data[bam_pkg::SEND_ONLY_POS];
      recv_only_nxt = i_wr_data[bam_pkg::RECV_ONLY_POS];
      // a mode change abandons any half-done extended address
      pri_nxt = bam_pkg::PRI_IDLE;
      hold_nxt = 1'b0;
      talk_nxt = talk_nxt || i_wr_data[bam_pkg::SEND_ONLY_POS];
      if (i_wr_data[bam_pkg::RECV_ONLY_POS])
      begin
        listen_nxt = 1'b1;
        talk_nxt = i_wr_data[bam_pkg::SEND_ONLY_POS];
      end
      // clearing only bits never drops the active state by itself
      minor_nxt = minor_nxt && i_wr_data[bam_pkg::MODE_LO_POS];
    end
  end

  // addressing registers
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      mode_r <= bam_pkg::MODE_RESET;
      dir_r <= bam_pkg::DIR_RESET;
      send_only_r <= 1'b0;
      recv_only_r <= 1'b0;
      talk_r <= 1'b0;
      listen_r <= 1'b0;
      minor_r <= 1'b0;
      pri_minor_r <= 1'b0;
      hold_r <= 1'b0;
      pri_r <= bam_pkg::PRI_IDLE;
    end
    else
    begin
      mode_r <= mode_nxt;
      dir_r <= dir_nxt;
      send_only_r <= send_only_nxt;
      recv_only_r <= recv_only_nxt;
      talk_r <= talk_nxt;
      listen_r <= listen_nxt;
      minor_r <= minor_nxt;
      pri_minor_r <= pri_minor_nxt;
      hold_r <= hold_nxt;
      pri_r <= pri_nxt;
    end
  end

  // ========================================================
  // status read path
  // status is a pure view of state; reading changes nothing
  always_comb
  begin
    status = 8'h00;
    status[bam_pkg::LPRI_SEEN_POS] = (pri_r == bam_pkg::PRI_LISTEN);
    status[bam_pkg::TPRI_SEEN_POS] = (pri_r == bam_pkg::PRI_TALK);
    status[bam_pkg::LISTEN_POS] = listen_r;
    status[bam_pkg::SEND_ROLE_POS] = talk_r;
    status[bam_pkg::MINOR_POS] = minor_r;
    rd_data_nxt = rd_hit ? status : bam_pkg::RD_RESET;
    rd_valid_nxt = rd_hit;
  end

  // read answer one cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rd_data_r <= bam_pkg::RD_RESET;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end
  // outputs straight from flops
  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;
  assign o_driver_dir_ctrl = dir_r;
  assign o_listen_active = listen_r;
  assign o_send_role = talk_r;
  assign o_sec_hold = hold_r;

  // ========================================================
  // checks
  property p_tpri_seen;
    @(posedge i_clock) disable iff (i_sys_rst)
    (cmd_take && ext_mode && is_talk && own_hit && !clear_cmd && !wr_hit)
      |=> (pri_r == bam_pkg::PRI_TALK) ##0 (status[bam_pkg::TPRI_SEEN_POS]);
  endproperty
  a_tpri_seen: assert property (p_tpri_seen) else $error("primary talk flag not set");
  property p_mode3_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    (cmd_take && (mode_r == bam_pkg::MODE_EXT_DUAL) && is_sec && (pri_r == bam_pkg::PRI_TALK)
      && !clear_cmd && !wr_hit) |=> (hold_r && status[bam_pkg::TPRI_SEEN_POS]);
  endproperty
  a_mode3_hold: assert property (p_mode3_hold) else $error("secondary not held");
  property p_listen_drops_talk;
    @(posedge i_clock) disable iff (i_sys_rst)
    ($rose(listen_r) && !send_only_r) |-> !talk_r;
  endproperty
  a_listen_drops_talk: assert property (p_listen_drops_talk) else $error("talk kept");
  // a new address may legally arrive right after the command, so only one cycle is checked
  property p_clear_listen;
    @(posedge i_clock) disable iff (i_sys_rst)
    (clear_cmd && !wr_hit) |=> !listen_r && !talk_r && !hold_r && (pri_r == bam_pkg::PRI_IDLE);
  endproperty
  a_clear_listen: assert property (p_clear_listen) else $error("reset cmd ignored");
  // the read answer lags one cycle, so it is checked against the mode it was taken in
  property p_minor_modes;
    @(posedge i_clock) disable iff (i_sys_rst)
    !mode_r[bam_pkg::MODE_LO_POS] |-> !minor_r ##1 !o_rd_data[bam_pkg::MINOR_POS];
  endproperty
  a_minor_modes: assert property (p_minor_modes) else $error("minor set in wrong mode");
  property p_send_only;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_hit && i_wr_data[bam_pkg::SEND_ONLY_POS]) |=> talk_r ##1 (o_send_role || clear_cmd
      || $past(cmd_take) || $past(clear_cmd) || $past(wr_hit));
  endproperty
  a_send_only: assert property (p_send_only) else $error("send-only not a talker");
  property p_talk_kept;
    @(posedge i_clock) disable iff (i_sys_rst)
    (talk_r && wr_hit && !i_wr_data[bam_pkg::SEND_ONLY_POS] && !cmd_take
      && !i_wr_data[bam_pkg::RECV_ONLY_POS] && !clear_cmd && !hold_r) |=> talk_r;
  endproperty
  a_talk_kept: assert property (p_talk_kept) else $error("talker lost on clear");
  property p_mode0_ignores;
    @(posedge i_clock) disable iff (i_sys_rst)
    ((mode_r == bam_pkg::MODE_ONLY) && i_cmd_valid && !wr_hit && !clear_cmd && !hold_r)
      |=> $stable(listen_r) && $stable(talk_r) && (pri_r == bam_pkg::PRI_IDLE);
  endproperty
  a_mode0_ignores: assert property (p_mode0_ignores) else $error("mode 0 took address");
  property p_read_view;
    @(posedge i_clock) disable iff (i_sys_rst)
    rd_hit |=> o_rd_valid && (o_rd_data[bam_pkg::LISTEN_POS] == $past(listen_r))
      && (o_rd_data[bam_pkg::SEND_ROLE_POS] == $past(talk_r));
  endproperty
  a_read_view: assert property (p_read_view) else $error("status read mismatch");
endmodule : bam_addr_status

//--- tb/bam_bus_model.sv
`timescale 1ns/1ns
// ==========================================================
// far-side bus controller: puts command bytes on the link
// ==========================================================
module bam_bus_model (
  input wire logic i_clock,
  output logic o_cmd_valid,
  output logic [6:0] o_cmd_byte
);
  // idle link at time zero
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_byte = 7'h55;
  end

  // one byte per call; gap lets the controller answer slowly
  task automatic send(input logic [6:0] b, input int gap);
    repeat (gap) @(posedge i_clock);
    @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd_byte <= b;
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    // inverse after release, so a stale byte is never mistaken for a live one
    o_cmd_byte <= ~b;
  endtask : send
endmodule : bam_bus_model

//--- tb/bus_address_status_mode_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// bench for the address status / mode block
// ==========================================================
module bus_address_status_mode_tb_top;
  typedef struct packed {logic [1:0] mode; logic [6:0] cmd; logic [7:0] exp;} bam_row_t;
  localparam logic [4:0] MAJOR = 5'h05;
  localparam logic [4:0] MINOR = 5'h0a;
  // mode, command byte, expected status after one byte
  localparam bam_row_t ROWS [9] = '{
    '{2'h1, 7'h45, 8'h02}, '{2'h1, 7'h4a, 8'h03}, '{2'h1, 7'h25, 8'h04},
    '{2'h1, 7'h2a, 8'h05}, '{2'h0, 7'h45, 8'h00}, '{2'h2, 7'h45, 8'h08},
    '{2'h2, 7'h25, 8'h10}, '{2'h3, 7'h45, 8'h08}, '{2'h1, 7'h47, 8'h00}};
  logic clock;
  logic sys_rst;
  logic [8:0] reg_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic rd_en;
  logic [3:0] aux;
  logic cmd_valid;
  logic [6:0] cmd_byte;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [1:0] dir_ctrl;
  logic listen_active;
  logic send_role;
  logic sec_hold;
  int errors;
  int n_checks;

  // ==========================================================
  // clock, design and far side
  // ==========================================================
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // aux bits: chip reset, power-on, valid verdict, non-valid verdict
  bam_addr_status dut (
    .i_clock(clock),
    .i_sys_rst(sys_rst),
    .i_reg_addr(reg_addr),
    .i_wr_en(wr_en),
    .i_wr_data(wr_data),
    .i_rd_en(rd_en),
    .i_chip_reset(aux[0]),
    .i_pon_cmd(aux[1]),
    .i_cmd_valid(cmd_valid),
    .i_cmd_byte(cmd_byte),
    .i_first_addr(MAJOR),
    .i_second_addr(MINOR),
    .i_sec_valid(aux[2]),
    .i_sec_invalid(aux[3]),
    .o_rd_data(rd_data),
    .o_rd_valid(rd_valid),
    .o_driver_dir_ctrl(dir_ctrl),
    .o_listen_active(listen_active),
    .o_send_role(send_role),
    .o_sec_hold(sec_hold)
  );

  bam_bus_model bus (
    .i_clock(clock),
    .o_cmd_valid(cmd_valid),
    .o_cmd_byte(cmd_byte)
  );

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // sample one step past the edge so registered outputs have landed
  task automatic settle();
    @(posedge clock);
    #1;
  endtask : settle

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    reg_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  // direction bits always one, reserved bits always zero
  task automatic set_mode(input logic [1:0] only, input logic [1:0] m);
    wr(bam_pkg::REG_OFFSET, {only, 2'h3, 2'h0, m});
  endtask : set_mode

  // answer stands for one cycle only, so it is looked at right then
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge clock);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check("rd_valid", {7'h00, rd_valid}, {7'h00, a === bam_pkg::REG_OFFSET});
    check("status", rd_data & mask, exp & mask);
  endtask : rd_chk

  task automatic aux_pulse(input logic [3:0] m);
    @(posedge clock);
    aux <= m;
    @(posedge clock);
    aux <= 4'h0;
  endtask : aux_pulse

  // ==========================================================
  // watchdog: whole run is under two hundred cycles, allow far more
  // ==========================================================
  initial
  begin
    #20000;
    errors = errors + 1;
    test_done();
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 9'h000;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
    aux = 4'h0;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    check("listen", {7'h00, listen_active}, 8'h00);
    check("send", {7'h00, send_role}, 8'h00);
    rd_chk(bam_pkg::REG_OFFSET, 8'h00, 8'hff);
    rd_chk(9'h118, 8'h00, 8'hff);
    // table: one address byte per row, chip reset between rows
    for (int i = 0; i < 9; i++)
    begin
      aux_pulse(4'h1);
      set_mode(2'h0, ROWS[i].mode);
      bus.send(ROWS[i].cmd, i % 3);
      rd_chk(bam_pkg::REG_OFFSET, ROWS[i].exp, 8'hff);
    end
    // listen address after talk address drops the talker
    aux_pulse(4'h1);
    set_mode(2'h0, 2'h1);
    bus.send(7'h45, 0);
    bus.send(7'h25, 0);
    rd_chk(bam_pkg::REG_OFFSET, 8'h04, 8'hff);
    bus.send(7'h4a, 0);
    rd_chk(bam_pkg::REG_OFFSET, 8'h03, 8'h03);
    // another talker's address drops our talker, unlisten drops our listener
    bus.send(7'h47, 0);
    rd_chk(bam_pkg::REG_OFFSET, 8'h04, 8'h06);
    bus.send(7'h3f, 0);
    rd_chk(bam_pkg::REG_OFFSET, 8'h00, 8'h06);
    set_mode(2'h0, 2'h2);
    rd_chk(bam_pkg::REG_OFFSET, 8'h00, 8'h01);
    // extended single: primary then matching secondary
    aux_pulse(4'h1);
    set_mode(2'h0, 2'h2);
    bus.send(7'h45, 0);
    bus.send(7'h6a, 2);
    rd_chk(bam_pkg::REG_OFFSET, 8'h02, 8'h0f);
    // extended dual: secondary held until software gives a verdict
    aux_pulse(4'h1);
    set_mode(2'h0, 2'h3);
    bus.send(7'h45, 0);
    bus.send(7'h61, 0);
    settle();
    check("hold", {7'h00, sec_hold}, 8'h01);
    bus.send(7'h5f, 0);
    aux_pulse(4'h4);
    settle();
    check("send", {7'h00, send_role}, 8'h01);
    check("hold", {7'h00, sec_hold}, 8'h00);
    rd_chk(bam_pkg::REG_OFFSET, 8'h02, 8'h0a);
    bus.send(7'h45, 0);
    bus.send(7'h62, 0);
    settle();
    check("hold", {7'h00, sec_hold}, 8'h01);
    aux_pulse(4'h8);
    settle();
    check("hold", {7'h00, sec_hold}, 8'h00);
    rd_chk(bam_pkg::REG_OFFSET, 8'h02, 8'h0a);
    // send-only: set, clear alone, then chip reset
    aux_pulse(4'h1);
    wr(9'h118, 8'hb0);
    settle();
    check("send", {7'h00, send_role}, 8'h00);
    set_mode(2'h2, 2'h0);
    settle();
    check("send", {7'h00, send_role}, 8'h01);
    check("dir", {6'h00, dir_ctrl}, 8'h03);
    set_mode(2'h0, 2'h0);
    settle();
    check("send", {7'h00, send_role}, 8'h01);
    rd_chk(bam_pkg::REG_OFFSET, 8'h02, 8'hff);
    rd_chk(bam_pkg::REG_OFFSET, 8'h02, 8'hff);
    aux_pulse(4'h1);
    settle();
    check("send", {7'h00, send_role}, 8'h00);
    // receive-only: set, clear alone, then power-on command
    set_mode(2'h1, 2'h0);
    settle();
    check("listen", {7'h00, listen_active}, 8'h01);
    set_mode(2'h0, 2'h0);
    settle();
    check("listen", {7'h00, listen_active}, 8'h01);
    aux_pulse(4'h2);
    settle();
    check("listen", {7'h00, listen_active}, 8'h00);
    test_done();
  end
endmodule : bus_address_status_mode_tb_top
